/* design/iec_pkg.sv */
// Purpose: Shared constants and types for the internal event comparator.
// Assumes: One 125 MHz clock; values are signed 16-bit display units.
// Notes: Event types follow the operation type codes of the controller.
package iec_pkg;
  // Number of internal event evaluators.
  localparam int IEC_N_EVT = 8;
  // Number of physical event output points built in (zero to three).
  localparam int IEC_N_OUT = 3;
  // One display unit: the least dead band kept on the far side of a threshold.
  localparam logic signed [15:0] IEC_ONE_U = 16'sh0001;
  // Diagnosis tick: 1 ms time base at 125 MHz.
  localparam int IEC_CLK_MHZ = 125;
  localparam int IEC_TICK_US = 1000;
  localparam int IEC_TICK_CYC = IEC_CLK_MHZ * IEC_TICK_US;
  // Operation type codes.
  localparam logic [4:0] IEC_T_NONE = 5'h00;
  localparam logic [4:0] IEC_T_PVH = 5'h01;
  localparam logic [4:0] IEC_T_PVL = 5'h02;
  localparam logic [4:0] IEC_T_PVHL = 5'h03;
  localparam logic [4:0] IEC_T_DVH = 5'h04;
  localparam logic [4:0] IEC_T_DVL = 5'h05;
  localparam logic [4:0] IEC_T_DVHL = 5'h06;
  localparam logic [4:0] IEC_T_FDVH = 5'h07;
  localparam logic [4:0] IEC_T_FDVL = 5'h08;
  localparam logic [4:0] IEC_T_FDVHL = 5'h09;
  localparam logic [4:0] IEC_T_CTBO = 5'h0A;
  localparam logic [4:0] IEC_T_CTSC = 5'h0B;
  localparam logic [4:0] IEC_T_LOOP1 = 5'h14;
  // Default routing: output k takes internal event k (one-hot over 8).
  localparam logic [7:0] IEC_ROUTE_RST0 = 8'h01;
  localparam logic [7:0] IEC_ROUTE_RST1 = 8'h02;
  localparam logic [7:0] IEC_ROUTE_RST2 = 8'h04;

  // Per-event configuration.
  typedef struct packed {
    logic [4:0] op_type;
    logic reverse;
    logic signed [15:0] main_set;
    logic signed [15:0] sub_set;
    logic signed [15:0] hysteresis_band;
    logic [15:0] on_delay_ms;
  } iec_cfg_t;

  // Process values shared by all evaluators.
  typedef struct packed {
    logic signed [15:0] pv;
    logic signed [15:0] sp_now;
    logic signed [15:0] sp_final;
    logic signed [15:0] mv;
    logic heat_mode;
    logic ct_measured;
    logic ct_alarm;
  } iec_proc_t;
endpackage

/* design/iec_hyst.sv */
// Purpose: One threshold comparator with a dead band.
// Assumes: Same clock as the evaluator; values are signed.
// Notes: Goes ON at or past the threshold, OFF beyond threshold minus band (high side) or plus band (low side).
`timescale 1ns/1ps
`default_nettype none
module iec_hyst
  import iec_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Comparison operands.
  input wire logic enable,
  input wire logic high_side,
  input wire logic signed [15:0] value,
  input wire logic signed [15:0] thresh,
  input wire logic signed [15:0] band,
  // Held comparison state.
  output logic state
);
  // Widened sums keep the band from wrapping at the range ends.
  logic signed [17:0] off_hi;
  logic signed [17:0] off_lo;
  logic [15:0] band_u;

  // A zero band still leaves one display unit of dead band.
  assign band_u = (band > IEC_ONE_U) ? band : IEC_ONE_U;
  assign off_hi = 18'(thresh) - 18'(signed'(band_u));
  assign off_lo = 18'(thresh) + 18'(signed'(band_u));

  // State is held between the ON and OFF points.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= 1'b0;
    end else if (!enable) begin
      state <= 1'b0;
    end else if (high_side) begin
      if (value >= thresh) begin
        state <= 1'b1; // R5
      end else if (18'(value) < off_hi) begin
        state <= 1'b0; // R5
      end
    end else begin
      if (value <= thresh) begin
        state <= 1'b1; // R5
      end else if (18'(value) > off_lo) begin
        state <= 1'b0; // R5
      end
    end
  end
endmodule
`default_nettype wire

/* design/iec_top.sv */
// Purpose: Eight internal event evaluators with output routing and IRQ.
// Assumes: Registers reached over a plain address/strobe port.
// Notes: Evaluation is continuous; the diagnosis timer ticks every 1 ms.
// How it works
// R1 - Eight independent evaluators with own settings.
// R2 - Zero to three physical event outputs.
// R3 - Reset routes events one-three to outputs.
// R4 - Events four-eight need explicit routing by software.
// R5 - Switch at threshold, release past hysteresis band.
// R6 - Types seven-nine use final setpoint.
// R7 - Main above sub gets swapped automatically.
// R8 - Type twenty: PV misses sub within time.
// R9 - Delay counts while both conditions hold.
// R10 - Current-sensor types OFF until first measurement.
// R11 - Reverse complements; no-event always OFF.
// R12 - Deviation compares PV with setpoint plus main.
`timescale 1ns/1ps
`default_nettype none
module iec_top
  import iec_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Process values from the control loop.
  input wire iec_proc_t proc_in,
  // Event results.
  output logic [IEC_N_EVT-1:0] event_state,
  output logic [IEC_N_OUT-1:0] event_out,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // Register map: each event owns two words from its base.
  localparam logic [7:0] IEC_A_STATE = 8'h00;
  localparam logic [7:0] IEC_A_ISTAT = 8'h04;
  localparam logic [7:0] IEC_A_IMASK = 8'h08;
  localparam logic [7:0] IEC_A_ROUTE = 8'h0C;
  localparam logic [7:0] IEC_A_EVT = 8'h40;

  // Event configuration registers.
  iec_cfg_t cfg_r [IEC_N_EVT];
  // Route masks, one per physical output.
  logic [7:0] route_r [IEC_N_OUT];
  // Sticky status and mask.
  logic [7:0] istat_r;
  logic [7:0] imask_r;
  // 1 ms enable pulse.
  logic [16:0] tick_cnt_r;
  logic tick;
  // Power-on latch of the first current measurement.
  logic ct_seen_r;
  // Previous event state for edge detection.
  logic [7:0] evt_prev_r;

  // Decodes an event-slot address into its index, or 8 if not one.
  function automatic logic [3:0] evt_slot(input logic [7:0] a);
    if (a[7:6] == IEC_A_EVT[7:6]) begin
      evt_slot = {1'b0, a[5:3]};
    end else begin
      evt_slot = 4'h8;
    end
  endfunction

  // Slot of the current address, shared by the write and read decoders.
  // A function result cannot be sliced directly, so it is held here.
  logic [3:0] slot_idx;
  assign slot_idx = evt_slot(addr);

  ////////////////////////////////////////////////////////////////////////
  // Tick divider for the diagnosis timers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 17'h00000;
    end else if (tick) begin
      tick_cnt_r <= 17'h00000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h00001;
    end
  end
  assign tick = (tick_cnt_r == 17'(IEC_TICK_CYC - 1));

  // Sensor current is unknown until the first measurement completes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ct_seen_r <= 1'b0;
    end else if (proc_in.ct_measured) begin
      ct_seen_r <= 1'b1; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration writes; each event slot is two words, and each band
  // has its own word at 0x20 + 4*event, below the slots.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < IEC_N_EVT; i++) begin
        cfg_r[i] <= '0;
      end
    end else if (wr_en && slot_idx != 4'h8) begin
      if (!addr[2]) begin
        cfg_r[slot_idx[2:0]].op_type <= wdata[4:0];
        cfg_r[slot_idx[2:0]].reverse <= wdata[8];
        cfg_r[slot_idx[2:0]].on_delay_ms <= wdata[31:16];
      end else begin
        cfg_r[slot_idx[2:0]].main_set <= wdata[15:0];
        cfg_r[slot_idx[2:0]].sub_set <= wdata[31:16];
      end
    end else if (wr_en && addr[7:5] == 3'h1) begin
      // Band word; a zero band still gives one unit of dead band.
      cfg_r[addr[4:2]].hysteresis_band <= wdata[15:0];
    end
  end

  // Routing writes; defaults connect events one to three only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      route_r[0] <= IEC_ROUTE_RST0; // R3
      route_r[1] <= IEC_ROUTE_RST1; // R3
      route_r[2] <= IEC_ROUTE_RST2; // R3
    end else if (wr_en && addr == IEC_A_ROUTE) begin
      for (int k = 0; k < IEC_N_OUT; k++) begin
        route_r[k] <= wdata[8*k +: 8]; // R4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Evaluators.
  genvar g;
  generate
    for (g = 0; g < IEC_N_EVT; g++) begin : g_evt // R1
      iec_cfg_t c;
      logic signed [15:0] sp_ref;
      logic signed [15:0] lo_set;
      logic signed [15:0] hi_set;
      logic signed [15:0] t_a;
      logic signed [15:0] t_b;
      logic a_hi;
      logic b_hi;
      logic use_b;
      logic thr_ok;
      logic st_a;
      logic st_b;
      logic direct;
      logic diag_cond;
      logic [15:0] dly_r;
      logic diag_on_r;
      logic raw;

      assign c = cfg_r[g];
      // Final setpoint for types 7 to 9, ramping setpoint otherwise.
      assign sp_ref = (c.op_type >= IEC_T_FDVH && c.op_type <= IEC_T_FDVHL)
        ? proc_in.sp_final : proc_in.sp_now; // R6
      // Two-threshold types use ordered bounds.
      assign lo_set = (c.main_set > c.sub_set) ? c.sub_set : c.main_set; // R7
      assign hi_set = (c.main_set > c.sub_set) ? c.main_set : c.sub_set; // R7

      // Threshold selection per type.
      always_comb begin
        t_a = c.main_set;
        t_b = hi_set;
        a_hi = 1'b1;
        b_hi = 1'b1;
        use_b = 1'b0;
        thr_ok = 1'b1;
        unique case (c.op_type)
          IEC_T_PVH: begin
          end
          IEC_T_PVL: begin
            a_hi = 1'b0;
          end
          IEC_T_PVHL: begin
            t_a = lo_set;
            a_hi = 1'b0;
            use_b = 1'b1;
          end
          IEC_T_DVH, IEC_T_FDVH: begin
            t_a = 16'(sp_ref + c.main_set); // R12
          end
          IEC_T_DVL, IEC_T_FDVL: begin
            t_a = 16'(sp_ref + c.main_set); // R12
            a_hi = 1'b0;
          end
          IEC_T_DVHL, IEC_T_FDVHL: begin
            t_a = 16'(sp_ref + lo_set); // R12
            t_b = 16'(sp_ref + hi_set); // R12
            a_hi = 1'b0;
            use_b = 1'b1;
          end
          default: begin
            thr_ok = 1'b0;
          end
        endcase
      end

      iec_hyst u_a (
        .clk(clk),
        .rst(rst),
        .enable(thr_ok),
        .high_side(a_hi),
        .value(proc_in.pv),
        .thresh(t_a),
        .band(c.hysteresis_band),
        .state(st_a)
      );
      iec_hyst u_b (
        .clk(clk),
        .rst(rst),
        .enable(thr_ok && use_b),
        .high_side(b_hi),
        .value(proc_in.pv),
        .thresh(t_b),
        .band(c.hysteresis_band),
        .state(st_b)
      );

      // Loop diagnosis: MV beyond main while PV short of sub.
      assign diag_cond = (c.op_type == IEC_T_LOOP1) &&
        (proc_in.heat_mode
          ? (proc_in.mv > c.main_set && proc_in.pv < c.sub_set)
          : (proc_in.mv < c.main_set && proc_in.pv > c.sub_set)); // R8

      // On-delay counts ms ticks only while both conditions hold.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          dly_r <= 16'h0000;
          diag_on_r <= 1'b0;
        end else if (!diag_cond) begin
          dly_r <= 16'h0000; // R9
          diag_on_r <= 1'b0;
        end else if (dly_r >= c.on_delay_ms) begin
          diag_on_r <= 1'b1; // R9
        end else if (tick) begin
          dly_r <= dly_r + 16'h0001; // R9
        end
      end

      // Direct result; reverse complements every type but no-event.
      assign direct = use_b ? (st_a | st_b) : st_a;
      always_comb begin
        unique case (c.op_type)
          IEC_T_NONE: raw = 1'b0; // R11
          IEC_T_CTBO, IEC_T_CTSC: raw = ct_seen_r &&
            (proc_in.ct_alarm ^ c.reverse); // R10
          IEC_T_LOOP1: raw = diag_on_r ^ c.reverse;
          default: raw = thr_ok && (direct ^ c.reverse); // R11
        endcase
      end
      assign event_state[g] = raw;

      ct_off_a: assert property (@(posedge clk) disable iff (rst) // R10
        ((c.op_type == IEC_T_CTBO || c.op_type == IEC_T_CTSC) &&
          !ct_seen_r) |-> !event_state[g])
        else $error("Sensor event active before first measurement.");
      none_off_a: assert property (@(posedge clk) disable iff (rst) // R11
        (c.op_type == IEC_T_NONE) |-> !event_state[g])
        else $error("No-event type produced an active result.");
      diag_cond_a: assert property (@(posedge clk) disable iff (rst) // R9
        !diag_cond |=> !diag_on_r)
        else $error("Diagnosis held without both conditions.");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Output routing: an output is high when any routed event is high.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_out <= '0;
    end else begin
      for (int k = 0; k < IEC_N_OUT; k++) begin
        event_out[k] <= |(route_r[k] & event_state); // R2
      end
    end
  end

  route_rst_a: assert property (@(posedge clk) disable iff (rst) // R3
    $rose(event_state[0]) && route_r[0] == IEC_ROUTE_RST0 |=> event_out[0])
    else $error("Event one not routed to output one.");
  route_empty_a: assert property (@(posedge clk) disable iff (rst) // R4
    route_r[1] == 8'h00 |=> !event_out[1])
    else $error("Unrouted output went active.");

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: rising event edges set sticky bits, W1C clears.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_prev_r <= 8'h00;
      istat_r <= 8'h00;
      imask_r <= 8'h00;
    end else begin
      evt_prev_r <= event_state;
      // Set wins over a clear in the same cycle.
      if (wr_en && addr == IEC_A_ISTAT) begin
        istat_r <= (istat_r & ~wdata[7:0]) | (event_state & ~evt_prev_r);
      end else begin
        istat_r <= istat_r | (event_state & ~evt_prev_r);
      end
      if (wr_en && addr == IEC_A_IMASK) begin
        imask_r <= wdata[7:0];
      end
    end
  end
  assign irq = |(istat_r & imask_r);

  // The level follows the unmasked status with no extra delay.
  irq_level_a: assert property (@(posedge clk) disable iff (rst)
    irq == (|(istat_r & imask_r)))
    else $error("Interrupt level does not follow status.");
  // A rising event sets its status bit even under a clearing write.
  stat_set_a: assert property (@(posedge clk) disable iff (rst)
    $rose(event_state[0]) |=> istat_r[0])
    else $error("Interrupt status not captured.");

  ////////////////////////////////////////////////////////////////////////
  // Read data one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (rd_en) begin
      if (addr == IEC_A_STATE) begin
        rdata <= {24'h000000, event_state};
      end else if (addr == IEC_A_ISTAT) begin
        rdata <= {24'h000000, istat_r};
      end else if (addr == IEC_A_IMASK) begin
        rdata <= {24'h000000, imask_r};
      end else if (addr == IEC_A_ROUTE) begin
        rdata <= {8'h00, route_r[2], route_r[1], route_r[0]};
      end else if (addr[7:5] == 3'h1) begin
        rdata <= {16'h0000, cfg_r[addr[4:2]].hysteresis_band};
      end else if (slot_idx != 4'h8 && !addr[2]) begin
        rdata <= {cfg_r[slot_idx[2:0]].on_delay_ms, 7'h00,
          cfg_r[slot_idx[2:0]].reverse, 3'h0,
          cfg_r[slot_idx[2:0]].op_type};
      end else if (slot_idx != 4'h8) begin
        rdata <= {cfg_r[slot_idx[2:0]].sub_set,
          cfg_r[slot_idx[2:0]].main_set};
      end else begin
        rdata <= 32'h00000000;
      end
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

/* sim/internal_event_comparator_tb.sv */
// Purpose: Self-checking bench for the internal event comparator.
// Assumes: 125 MHz clock, plain register port, read data one cycle late.
// Notes: Test points keep clear of exact switch edges by at least one unit.
`timescale 1ns/1ps
`default_nettype none
module internal_event_comparator_tb import iec_pkg::*;;
  ////////////////////////////////////////
  // Design signals.
  logic clk;
  logic rst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata;
  iec_proc_t p;
  logic [IEC_N_EVT-1:0] event_state;
  logic [IEC_N_OUT-1:0] event_out;
  logic irq;
  // Counters and the seed of the random stream.
  int bad_count = 0;
  int checked = 0;
  int seed = 49;
  int cyc = 0;
  // Event set-up table: type, reverse, main and sub per event.
  int tyt[8] = '{1, 1, 2, 3, 4, 7, 9, 8};
  int rvt[8] = '{0, 1, 0, 0, 0, 0, 0, 1};
  int mnt[8] = '{100, 100, 100, 300, 100, 100, 300, 100};
  int sbt[8] = '{0, 0, 0, 100, 0, 0, 100, 0};
  // Offsets from a base; none lands on a switch point.
  int offs[7] = '{-200, 95, 105, 200, 295, 305, 400};
  // Model state: comparator halves, events, status, mask, routing.
  logic [7:0] hs, ls, ev, stat, msk;
  logic [31:0] rte, rdv;

  iec_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .proc_in(p),
    .event_state(event_state), .event_out(event_out), .irq(irq));

  ////////////////////////////////////////
  // Clock of 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard: the whole run needs a few thousand cycles at most.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("ERROR %0t run too long", $time);
      summarize();
    end
  end

  ////////////////////////////////////////
  // Verdict; the only place where the run ends.
  task summarize;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Value compare; narrower results are zero-extended.
  task cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Reset held for 16 cycles.
  task do_reset;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // Let comparator, routing and status registers land, then step off edge.
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // One-cycle write; an idle cycle follows so strobes never double up.
  task wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  // One-cycle read; data is taken in the cycle after the strobe.
  task rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  ////////////////////////////////////////
  // High side: on at or above t, off below t minus band, else hold.
  function automatic logic nh(logic s, int v, int t, int b);
    return (v >= t) ? 1'b1 : ((v < t - b) ? 1'b0 : s);
  endfunction

  // Low side mirrors the high side.
  function automatic logic nl(logic s, int v, int t, int b);
    return (v <= t) ? 1'b1 : ((v > t + b) ? 1'b0 : s);
  endfunction

  // Output k is the OR of the events picked by byte k of the route word.
  function automatic logic [2:0] rt(input logic [7:0] e);
    for (int k = 0; k < 3; k++)
      rt[k] = |(e & rte[8*k +: 8]);
  endfunction

  // Drive one process value and check events, outputs and interrupt.
  task step(input int v);
    int k, r, lo, hi;
    logic d;
    logic [7:0] ne;
    @(posedge clk);
    p.pv <= 16'(v);
    settle();
    for (int i = 0; i < 8; i++) begin
      k = (tyt[i] - 1) % 3;
      r = (tyt[i] < 4) ? 0 : ((tyt[i] < 7) ? 2000 : 4000);
      // Two-sided types order their bounds whichever way they were set.
      lo = (k == 2 && sbt[i] < mnt[i]) ? sbt[i] : mnt[i];
      hi = (k == 2 && sbt[i] > mnt[i]) ? sbt[i] : mnt[i];
      hs[i] = nh(hs[i], v, r + hi, 10);
      ls[i] = nl(ls[i], v, r + lo, 10);
      d = (k == 0) ? hs[i] : ((k == 1) ? ls[i] : (hs[i] | ls[i]));
      ne[i] = d ^ rvt[i][0];
    end
    stat = stat | (ne & ~ev);
    ev = ne;
    cmp(event_state, ev, "event state");
    cmp(event_out, rt(ev), "routed outputs");
    cmp(irq, |(stat & msk), "irq level");
  endtask

  ////////////////////////////////////////
  // Main sequence.
  initial begin
    int b, o;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    p = '0;
    @(posedge clk);
    // Defaults after reset, and an unmapped read.
    do_reset();
    settle();
    cmp(event_state, 8'h00, "state after reset");
    cmp(irq, 1'b0, "irq after reset");
    rd(8'h0C, rdv);
    cmp(rdv, 32'h00040201, "route reset");
    rd(8'hFC, rdv);
    cmp(rdv, 32'h0, "unmapped read");
    $display("test reset done");
    // Sensor types stay off until the first measurement, either sense.
    wr(8'h48, 32'h0000000A);
    wr(8'h50, 32'h0000010B);
    wr(8'h58, 32'h00000100);
    settle();
    cmp(event_state, 8'h00, "sensor before measure");
    p.ct_measured <= 1'b1;
    @(posedge clk);
    p.ct_measured <= 1'b0;
    settle();
    cmp(event_state, 8'h04, "sensor alarm clear");
    p.ct_alarm <= 1'b1;
    settle();
    cmp(event_state, 8'h02, "sensor alarm set");
    cmp(event_out, 3'b010, "default routing");
    $display("test sensor done");
    // Thresholds: all eight events, parked far below every bound.
    do_reset();
    p.pv <= -16'sd10000;
    p.sp_now <= 16'sd2000;
    p.sp_final <= 16'sd4000;
    for (int i = 0; i < 8; i++) begin
      wr(8'h20 + 8'(4 * i), 32'd10);
      wr(8'h40 + 8'(8 * i), 32'(rvt[i] * 256 + tyt[i]));
      wr(8'h44 + 8'(8 * i), {16'(sbt[i]), 16'(mnt[i])});
    end
    settle();
    hs = 8'h00;
    ls = 8'hFF;
    for (int i = 0; i < 8; i++)
      ev[i] = (((tyt[i] - 1) % 3) != 0) ^ rvt[i][0];
    cmp(event_state, ev, "parked low");
    // Start the status from zero; the set-up may have raised bits.
    wr(8'h04, 32'hFF);
    stat = 8'h00;
    msk = 8'h00;
    rte = 32'h00040201;
    for (int n = 0; n < 48; n++) begin
      // Halfway, events five and eight take outputs one and three;
      // output two is left with no event routed to it.
      if (n == 24) begin
        wr(8'h0C, 32'h00800010);
        rte = 32'h00800010;
      end
      b = int'($unsigned($random(seed)) % 3);
      o = int'($unsigned($random(seed)) % 7);
      step(b * 2000 + offs[o]);
    end
    rd(8'h04, rdv);
    cmp(rdv, stat, "sticky status");
    rd(8'h00, rdv);
    cmp(rdv, ev, "state register");
    rd(8'h20, rdv);
    cmp(rdv, 32'd10, "band readback");
    $display("test thresholds done");
    // Interrupt: unmask all, clear part, then raise event one alone.
    wr(8'h08, 32'hFF);
    msk = 8'hFF;
    step(-200);
    wr(8'h04, 32'h0F);
    stat = stat & 8'hF0;
    step(-200);
    wr(8'h08, 32'h01);
    msk = 8'h01;
    step(-200);
    step(400);
    $display("test interrupt done");
    // Loop diagnosis in heat mode: must wait out the delay first.
    do_reset();
    p.heat_mode <= 1'b1;
    p.pv <= 16'sd0;
    p.mv <= 16'sd800;
    wr(8'h44, 32'h03E801F4);
    wr(8'h40, 32'h00020014);
    repeat (2000) @(posedge clk);
    #1;
    cmp(event_state[0], 1'b0, "diag before delay");
    p.mv <= 16'sd0;
    wr(8'h40, 32'h00000014);
    p.mv <= 16'sd800;
    for (int n = 0; n < 100 && event_state[0] !== 1'b1; n++)
      @(posedge clk);
    #1;
    cmp(event_state[0], 1'b1, "diag expired");
    // Dropping the MV condition ends the event at once.
    p.mv <= 16'sd0;
    settle();
    cmp(event_state[0], 1'b0, "diag dropped");
    // Cool mode mirrors both conditions: MV below main, PV above sub.
    p.heat_mode <= 1'b0;
    p.pv <= 16'sd2000;
    settle();
    cmp(event_state[0], 1'b1, "diag cool mode");
    $display("test diagnosis done");
    summarize();
  end
endmodule
`default_nettype wire
